// file: design/ptz_params.svh
`ifndef PTZ_PARAMS_SVH
`define PTZ_PARAMS_SVH

`define PTZ_OFS_INSERT_SELECT 12'h982
`define PTZ_OFS_Z5_VALUE 12'h9B3
`define PTZ_OFS_PATH_CTRL 12'h9B7
`define PTZ_OFS_FORCED_H1 12'h9BF
`define PTZ_OFS_FORCED_H2 12'h9C3
`define PTZ_OFS_CUR_PTR_HI 12'h9C7
`define PTZ_OFS_CUR_PTR_LO 12'h9CB

`define PTZ_SEL_Z5_BIT 3
`define PTZ_PC_FORCE_BIT 5
`define PTZ_PC_CHECK_BIT 4
`define PTZ_PC_NEG_BIT 3
`define PTZ_PC_POS_BIT 2
`define PTZ_PC_CNDF_BIT 1
`define PTZ_PC_SNDF_BIT 0

`define PTZ_RST_BYTE 8'h00
`define PTZ_NDF_NORMAL 4'h6
`define PTZ_NDF_SET 4'h9
`define PTZ_I_MASK 10'h2AA
`define PTZ_D_MASK 10'h155

`define PTZ_CLK_PERIOD_PS 4000
`define PTZ_OHC_PERIOD_NS 32
`define PTZ_OHC_HALF_CYC ((`PTZ_OHC_PERIOD_NS * 1000 / `PTZ_CLK_PERIOD_PS) / 2)
`define PTZ_Z5_BYTE_POS 9
`define PTZ_BITS_PER_BYTE 8
`define PTZ_WAIT_PERIODS ((`PTZ_Z5_BYTE_POS - 1) * `PTZ_BITS_PER_BYTE)
`define PTZ_QUIET_FRAMES 3

`endif

// file: design/ptz_pkg.sv
package ptz_pkg;

   typedef enum logic [1:0]
   {
      PTZ_KIND_PAYLOAD = 2'b00,
      PTZ_KIND_H1 = 2'b01,
      PTZ_KIND_H2 = 2'b10,
      PTZ_KIND_Z5 = 2'b11
   } ptz_kind_t;

   typedef struct packed
   {
      ptz_kind_t kind;
      logic [7:0] data;
   } ptz_byte_t;

   typedef enum logic [1:0]
   {
      PTZ_OH_IDLE = 2'b00,
      PTZ_OH_MARK = 2'b01,
      PTZ_OH_COUNT = 2'b10
   } ptz_oh_state_t;

endpackage

// file: design/ptz_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ptz_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH)) && ce_i;
   assign out_valid_o = (cnt_q != '0) && ce_i;
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb
   begin
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push)
      begin
         wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop)
      begin
         rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      if (push && !pop)
      begin
         cnt_d = cnt_q + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
         cnt_d = cnt_q - (AW+1)'(1);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else if (ce_i)
      begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         if (push)
         begin
            mem_q[wr_q] <= in_data_i;
         end
      end
   end
endmodule // ptz_fifo
`default_nettype wire

// file: design/ptz_tx_path.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptz_params.svh"
module ptz_tx_path #(
   parameter logic [3:0] CHANNEL = 4'h1,
   parameter int FIFO_DEPTH = 4
) (
   // Clock, reset and enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Microprocessor register port
   input wire logic [15:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Outbound frame timing
   input wire logic frame_start_i,
   // Outbound byte stream in
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire ptz_pkg::ptz_byte_t in_byte_i,
   // Outbound byte stream out
   output logic out_valid_o,
   input wire logic out_ready_i,
   output ptz_pkg::ptz_byte_t out_byte_o,
   // Serial overhead port
   output logic overhead_clock_out_o,
   output logic overhead_window_out_o,
   output logic overhead_frame_mark_out_o,
   input wire logic overhead_serial_in_i
);
   import ptz_pkg::*;

   localparam logic [2:0] HALF = 3'(`PTZ_OHC_HALF_CYC);
   localparam logic [6:0] FIRST_BIT = 7'(`PTZ_WAIT_PERIODS + 1);
   localparam logic [6:0] LAST_BIT = 7'(`PTZ_WAIT_PERIODS + `PTZ_BITS_PER_BYTE);
   localparam logic [1:0] QUIET = 2'(`PTZ_QUIET_FRAMES);

   // Register bank.
   logic [3:0] sel_q, sel_d;
   logic [7:0] z5_val_q, z5_val_d;
   logic [7:0] fh1_q, fh1_d;
   logic [7:0] fh2_q, fh2_d;
   logic force_bit_q, force_bit_d, check_q, check_d;
   logic cndf_q, cndf_d, sndf_bit_q, sndf_bit_d;
   logic force_pend_q, force_pend_d, neg_pend_q, neg_pend_d;
   logic pos_pend_q, pos_pend_d, sndf_pend_q, sndf_pend_d;
   logic [7:0] rdata_q, rdata_d;
   // Pointer generation.
   logic [9:0] ptr_q, ptr_d;
   logic [7:0] h1_q, h1_d, h2_q, h2_d;
   logic [1:0] since_q, since_d;
   // Overhead port.
   logic [2:0] div_q, div_d;
   logic ohc_q, ohc_d;
   logic rise_dly1_q, rise_dly2_q;
   logic sin_meta_q, sin_sync_q;
   ptz_oh_state_t oh_q, oh_d;
   logic mark_pend_q, mark_pend_d;
   logic [6:0] rcnt_q, rcnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] z5_port_q, z5_port_d;

   logic hit, rise_tick, quiet, any_event;
   logic [11:0] ofs;
   ptz_byte_t fifo_in;

   assign hit = (reg_addr_i[15:12] == CHANNEL);
   assign ofs = reg_addr_i[11:0];
   assign rise_tick = (div_q == 3'(2 * HALF - 1));
   assign quiet = !check_q || (since_q >= QUIET);
   assign any_event = force_pend_q || neg_pend_q || pos_pend_q || sndf_pend_q || cndf_q;

   // Register access and pointer events.
   always_comb
   begin
      sel_d = sel_q;
      z5_val_d = z5_val_q;
      fh1_d = fh1_q;
      fh2_d = fh2_q;
      force_bit_d = force_bit_q;
      check_d = check_q;
      cndf_d = cndf_q;
      sndf_bit_d = sndf_bit_q;
      force_pend_d = force_pend_q;
      neg_pend_d = neg_pend_q;
      pos_pend_d = pos_pend_q;
      sndf_pend_d = sndf_pend_q;
      ptr_d = ptr_q;
      h1_d = h1_q;
      h2_d = h2_q;
      since_d = since_q;
      rdata_d = rdata_q;
      // Frame boundary: pick at most one pointer event for this frame.
      if (frame_start_i)
      begin
         h1_d = {`PTZ_NDF_NORMAL, 2'b00, ptr_q[9:8]};
         h2_d = ptr_q[7:0];
         since_d = (since_q == QUIET) ? since_q : since_q + 2'(1);
         if (any_event && quiet)
         begin
            since_d = '0;
            if (force_pend_q)
            begin
               force_pend_d = 1'b0;
               ptr_d = {fh1_q[1:0], fh2_q};
               h1_d = fh1_q;
               h2_d = fh2_q;
            end
            else if (neg_pend_q)
            begin
               neg_pend_d = 1'b0;
               {h1_d[1:0], h2_d} = ptr_q ^ `PTZ_D_MASK;
               ptr_d = ptr_q - 10'(1);
            end
            else if (pos_pend_q)
            begin
               pos_pend_d = 1'b0;
               {h1_d[1:0], h2_d} = ptr_q ^ `PTZ_I_MASK;
               ptr_d = ptr_q + 10'(1);
            end
            else
            begin
               sndf_pend_d = 1'b0;
               ptr_d = {fh1_q[1:0], fh2_q};
               h1_d = {`PTZ_NDF_SET, fh1_q[3:0]};
               h2_d = fh2_q;
            end
         end
      end
      // Writes come after the frame logic so that a new request wins.
      if (reg_wr_i && hit)
      begin
         if (ofs == `PTZ_OFS_INSERT_SELECT)
         begin
            sel_d = reg_wdata_i[3:0];
         end
         else if (ofs == `PTZ_OFS_Z5_VALUE)
         begin
            z5_val_d = reg_wdata_i;
         end
         else if (ofs == `PTZ_OFS_PATH_CTRL)
         begin
            force_bit_d = reg_wdata_i[`PTZ_PC_FORCE_BIT];
            check_d = reg_wdata_i[`PTZ_PC_CHECK_BIT];
            cndf_d = reg_wdata_i[`PTZ_PC_CNDF_BIT];
            sndf_bit_d = reg_wdata_i[`PTZ_PC_SNDF_BIT];
            if (reg_wdata_i[`PTZ_PC_FORCE_BIT] && !force_bit_q)
            begin
               force_pend_d = 1'b1;
            end
            if (reg_wdata_i[`PTZ_PC_NEG_BIT])
            begin
               neg_pend_d = 1'b1;
            end
            if (reg_wdata_i[`PTZ_PC_POS_BIT])
            begin
               pos_pend_d = 1'b1;
            end
            if (reg_wdata_i[`PTZ_PC_SNDF_BIT] && !sndf_bit_q)
            begin
               sndf_pend_d = 1'b1;
            end
         end
         else if (ofs == `PTZ_OFS_FORCED_H1)
         begin
            fh1_d = reg_wdata_i;
         end
         else if (ofs == `PTZ_OFS_FORCED_H2)
         begin
            fh2_d = reg_wdata_i;
         end
      end
      // Read data is registered; unmapped offsets read zero.
      if (reg_rd_i)
      begin
         rdata_d = `PTZ_RST_BYTE;
         if (!hit)
         begin
            rdata_d = `PTZ_RST_BYTE;
         end
         else if (ofs == `PTZ_OFS_INSERT_SELECT)
         begin
            rdata_d = {4'h0, sel_q};
         end
         else if (ofs == `PTZ_OFS_Z5_VALUE)
         begin
            rdata_d = z5_val_q;
         end
         else if (ofs == `PTZ_OFS_PATH_CTRL)
         begin
            rdata_d = {2'b00, force_bit_q, check_q, 2'b00, cndf_q, sndf_bit_q};
         end
         else if (ofs == `PTZ_OFS_FORCED_H1)
         begin
            rdata_d = fh1_q;
         end
         else if (ofs == `PTZ_OFS_FORCED_H2)
         begin
            rdata_d = fh2_q;
         end
         else if (ofs == `PTZ_OFS_CUR_PTR_HI)
         begin
            rdata_d = {6'h00, ptr_q[9:8]};
         end
         else if (ofs == `PTZ_OFS_CUR_PTR_LO)
         begin
            rdata_d = ptr_q[7:0];
         end
      end
   end

   // Overhead clock divider and serial Z5 capture.
   always_comb
   begin
      div_d = (div_q == 3'(2 * HALF - 1)) ? '0 : div_q + 3'(1);
      ohc_d = (div_d < HALF);
      oh_d = oh_q;
      mark_pend_d = mark_pend_q || frame_start_i;
      rcnt_d = rcnt_q;
      shift_d = shift_q;
      z5_port_d = z5_port_q;
      if (rise_tick)
      begin
         case (oh_q)
            PTZ_OH_IDLE:
            begin
               if (mark_pend_q)
               begin
                  mark_pend_d = frame_start_i;
                  oh_d = PTZ_OH_MARK;
                  rcnt_d = '0;
               end
            end
            PTZ_OH_MARK:
            begin
               oh_d = PTZ_OH_COUNT;
               rcnt_d = 7'(1);
            end
            PTZ_OH_COUNT:
            begin
               rcnt_d = rcnt_q + 7'(1);
               if (rcnt_q == LAST_BIT)
               begin
                  oh_d = PTZ_OH_IDLE;
               end
            end
            default:
            begin
               oh_d = PTZ_OH_IDLE;
            end
         endcase
      end
      // The sample point trails the rise by the synchroniser's two cycles.
      if (rise_dly2_q && oh_q == PTZ_OH_COUNT && rcnt_q >= FIRST_BIT && rcnt_q <= LAST_BIT)
      begin
         shift_d = {shift_q[6:0], sin_sync_q};
         if (rcnt_q == LAST_BIT)
         begin
            z5_port_d = {shift_q[6:0], sin_sync_q};
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sel_q <= '0;
         z5_val_q <= `PTZ_RST_BYTE;
         fh1_q <= `PTZ_RST_BYTE;
         fh2_q <= `PTZ_RST_BYTE;
         force_bit_q <= 1'b0;
         check_q <= 1'b0;
         cndf_q <= 1'b0;
         sndf_bit_q <= 1'b0;
         force_pend_q <= 1'b0;
         neg_pend_q <= 1'b0;
         pos_pend_q <= 1'b0;
         sndf_pend_q <= 1'b0;
         rdata_q <= `PTZ_RST_BYTE;
         ptr_q <= '0;
         h1_q <= {`PTZ_NDF_NORMAL, 4'h0};
         h2_q <= `PTZ_RST_BYTE;
         since_q <= QUIET;
         // Starting at the wrap gives the overhead clock a full first high phase.
         div_q <= 3'(2 * HALF - 1);
         ohc_q <= 1'b0;
         rise_dly1_q <= 1'b0;
         rise_dly2_q <= 1'b0;
         sin_meta_q <= 1'b0;
         sin_sync_q <= 1'b0;
         oh_q <= PTZ_OH_IDLE;
         mark_pend_q <= 1'b0;
         rcnt_q <= '0;
         shift_q <= '0;
         z5_port_q <= `PTZ_RST_BYTE;
      end
      else if (ce_i)
      begin
         sel_q <= sel_d;
         z5_val_q <= z5_val_d;
         fh1_q <= fh1_d;
         fh2_q <= fh2_d;
         force_bit_q <= force_bit_d;
         check_q <= check_d;
         cndf_q <= cndf_d;
         sndf_bit_q <= sndf_bit_d;
         force_pend_q <= force_pend_d;
         neg_pend_q <= neg_pend_d;
         pos_pend_q <= pos_pend_d;
         sndf_pend_q <= sndf_pend_d;
         rdata_q <= rdata_d;
         ptr_q <= ptr_d;
         h1_q <= h1_d;
         h2_q <= h2_d;
         since_q <= since_d;
         div_q <= div_d;
         ohc_q <= ohc_d;
         rise_dly1_q <= rise_tick;
         rise_dly2_q <= rise_dly1_q;
         sin_meta_q <= overhead_serial_in_i;
         sin_sync_q <= sin_meta_q;
         oh_q <= oh_d;
         mark_pend_q <= mark_pend_d;
         rcnt_q <= rcnt_d;
         shift_q <= shift_d;
         z5_port_q <= z5_port_d;
      end
   end

   // Byte substitution in front of the output FIFO.
   always_comb
   begin
      fifo_in = in_byte_i;
      if (in_byte_i.kind == PTZ_KIND_Z5)
      begin
         fifo_in.data = sel_q[`PTZ_SEL_Z5_BIT] ? z5_port_q : z5_val_q;
      end
      else if (in_byte_i.kind == PTZ_KIND_H1)
      begin
         fifo_in.data = h1_q;
      end
      else if (in_byte_i.kind == PTZ_KIND_H2)
      begin
         fifo_in.data = h2_q;
      end
   end

   ptz_fifo #(
      .WIDTH($bits(ptz_byte_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .in_valid_i(in_valid_i),
      .in_ready_o(in_ready_o),
      .in_data_i(fifo_in),
      .out_valid_o(out_valid_o),
      .out_ready_i(out_ready_i),
      .out_data_o(out_byte_o)
   );

   assign reg_rdata_o = rdata_q;
   assign overhead_clock_out_o = ohc_q;
   assign overhead_window_out_o = (oh_q == PTZ_OH_MARK);
   assign overhead_frame_mark_out_o = (oh_q == PTZ_OH_MARK);
endmodule // ptz_tx_path
`default_nettype wire

// file: tb/ptz_tx_path_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ptz_tx_path_checker #(
   parameter logic [3:0] CHANNEL = 4'h1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Register port
   input wire logic [15:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // Stream
   input wire logic in_valid_i,
   input wire logic in_ready_o,
   input wire ptz_pkg::ptz_byte_t in_byte_i,
   input wire logic out_valid_o,
   input wire ptz_pkg::ptz_byte_t out_byte_o,
   // Overhead port
   input wire logic overhead_clock_out_o,
   input wire logic overhead_window_out_o,
   input wire logic overhead_frame_mark_out_o
);
   import ptz_pkg::*;
   logic [7:0] z5_q, z5_d;
   logic sel_q, sel_d;
   logic hit;
   logic push;
   assign hit = ce_i && reg_wr_i && reg_addr_i[15:12] == CHANNEL;
   assign push = in_valid_i && in_ready_o && !out_valid_o;
   always_comb
   begin
      z5_d = z5_q;
      sel_d = sel_q;
      if (hit && reg_addr_i[11:0] == 12'h9B3) z5_d = reg_wdata_i;
      if (hit && reg_addr_i[11:0] == 12'h982) sel_d = reg_wdata_i[3];
   end
   always_ff @(posedge clk_i)
   begin
      z5_q <= rst_i ? 8'h00 : z5_d;
      sel_q <= rst_i ? 1'b0 : sel_d;
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   ohc_period_a: assert property (
      $rose(overhead_clock_out_o) |-> overhead_clock_out_o[*4] ##1
      !overhead_clock_out_o[*4] ##1 overhead_clock_out_o) else $error("bad overhead clock");
   mark_same_a: assert property (
      overhead_window_out_o == overhead_frame_mark_out_o) else $error("mark differs");
   window_rise_a: assert property (
      $rose(overhead_window_out_o) |-> $rose(overhead_clock_out_o)) else $error("window phase");
   window_len_a: assert property (
      $rose(overhead_window_out_o) |-> overhead_window_out_o[*8] ##1 !overhead_window_out_o)
      else $error("window length");
   unmapped_read_a: assert property (
      reg_rd_i && ce_i && reg_addr_i[11:0] == 12'h123 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read");
   select_read_a: assert property (
      reg_rd_i && ce_i && reg_addr_i == {CHANNEL, 12'h982} |=>
      reg_rdata_o[7:3] == {4'h0, $past(sel_q)})
      else $error("select readback");
   soft_z5_a: assert property (
      push && in_byte_i.kind == PTZ_KIND_Z5 && !sel_q |=> out_byte_o.data == $past(z5_q))
      else $error("z5 not from register");
   payload_pass_a: assert property (
      push && in_byte_i.kind == PTZ_KIND_PAYLOAD |=> out_valid_o && out_byte_o == $past(in_byte_i))
      else $error("payload altered");
   rdata_hold_a: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
endmodule // ptz_tx_path_checker
bind ptz_tx_path ptz_tx_path_checker #(.CHANNEL(CHANNEL)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i),
   .in_ready_o(in_ready_o), .in_byte_i(in_byte_i), .out_valid_o(out_valid_o),
   .out_byte_o(out_byte_o), .overhead_clock_out_o(overhead_clock_out_o),
   .overhead_window_out_o(overhead_window_out_o),
   .overhead_frame_mark_out_o(overhead_frame_mark_out_o));
`default_nettype wire

// file: tb/ptz_oh_inserter.sv
`timescale 1ns/1ps
`default_nettype none
module ptz_oh_inserter (
   // Clock and device pins; no insert request is driven in port mode.
   input wire logic clk_i,
   input wire logic ohc_i,
   input wire logic window_i,
   input wire logic mark_i,
   // Byte sent in each frame
   input wire logic [7:0] byte_i,
   output logic sdi_o
);
   logic prev;
   logic rise;
   logic fall;
   assign rise = ohc_i && !prev;
   assign fall = !ohc_i && prev;
   always @(posedge clk_i)
      prev <= ohc_i;
   task automatic next_edge(input logic up);
      do @(posedge clk_i); while (!(up ? rise : fall));
      #1;
   endtask
   // The pin shows the inverse of the last bit once its hold time is over.
   initial
   begin
      sdi_o = 1'b0;
      forever
      begin
         next_edge(1'b1);
         if (window_i === 1'b1 && mark_i === 1'b1)
         begin
            repeat (64) next_edge(1'b1);
            for (int i = 7; i >= 0; i--)
            begin
               next_edge(1'b0);
               sdi_o = byte_i[i];
            end
            next_edge(1'b0);
            sdi_o = ~sdi_o;
         end
      end
   end
endmodule // ptz_oh_inserter
`default_nettype wire

// file: tb/ptz_tx_path_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ptz_tx_path_tb_top;
   import ptz_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic fs = 1'b0;
   logic iv = 1'b0;
   logic ir;
   ptz_byte_t ib = '0;
   logic ov;
   logic ordy = 1'b0;
   ptz_byte_t ob;
   logic ohc, win, mark, sdi;
   logic [7:0] ins_byte = 8'h00;
   int err_total = 0;
   int compares = 0;
   always #2 clk = ~clk;
   ptz_tx_path #(.CHANNEL(4'h1), .FIFO_DEPTH(4)) u_dut (.clk_i(clk), .rst_i(rst), .ce_i(ce),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .frame_start_i(fs), .in_valid_i(iv), .in_ready_o(ir),
      .in_byte_i(ib), .out_valid_o(ov), .out_ready_i(ordy), .out_byte_o(ob),
      .overhead_clock_out_o(ohc), .overhead_window_out_o(win),
      .overhead_frame_mark_out_o(mark), .overhead_serial_in_i(sdi));
   ptz_oh_inserter u_ins (.clk_i(clk), .ohc_i(ohc), .window_i(win), .mark_i(mark),
      .byte_i(ins_byte), .sdi_o(sdi));
   task automatic wrap_up;
      if (err_total == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [11:0] o, input logic [7:0] d, input logic [3:0] c = 4'h1);
      addr = {c, o};
      wdata = d;
      wr = 1'b1;
      tick();
      wr = 1'b0;
      tick();
   endtask
   task automatic rd_chk(input logic [11:0] o, input logic [7:0] e);
      addr = {4'h1, o};
      rd = 1'b1;
      tick();
      rd = 1'b0;
      check(rdata, e);
      tick();
   endtask
   task automatic push(input ptz_kind_t k, input logic [7:0] d);
      iv = 1'b1;
      ib = '{kind: k, data: d};
      for (int n = 0; n < 50 && ir !== 1'b1; n++) tick();
      tick();
      iv = 1'b0;
      tick();
   endtask
   task automatic pop_chk(input ptz_kind_t k, input logic [7:0] d);
      ordy = 1'b1;
      for (int n = 0; n < 50 && ov !== 1'b1; n++) tick();
      check(ob, {k, d});
      tick();
      ordy = 1'b0;
      tick();
   endtask
   task automatic frame;
      fs = 1'b1;
      tick();
      fs = 1'b0;
      tick();
   endtask
   task automatic t_regs;
      rd_chk(12'h982, 8'h00);
      rd_chk(12'h9B3, 8'h00);
      rd_chk(12'h9BF, 8'h00);
      rd_chk(12'h9C3, 8'h00);
      wr_reg(12'h982, 8'hF7);
      rd_chk(12'h982, 8'h07);
      wr_reg(12'h9B3, 8'hA5);
      wr_reg(12'h9B3, 8'h11, 4'h2);
      rd_chk(12'h9B3, 8'hA5);
      wr_reg(12'h9BF, 8'h5A);
      rd_chk(12'h9BF, 8'h5A);
      wr_reg(12'h9C3, 8'hC3);
      rd_chk(12'h9C3, 8'hC3);
      rd_chk(12'h123, 8'h00);
   endtask
   // The far side stalls until four words are held and input is refused.
   task automatic t_soft;
      push(PTZ_KIND_PAYLOAD, 8'h77);
      push(PTZ_KIND_Z5, 8'h00);
      push(PTZ_KIND_Z5, 8'hFF);
      push(PTZ_KIND_PAYLOAD, 8'h22);
      check(ir, 1'b0);
      wr_reg(12'h9B3, 8'h3C);
      pop_chk(PTZ_KIND_PAYLOAD, 8'h77);
      pop_chk(PTZ_KIND_Z5, 8'hA5);
      pop_chk(PTZ_KIND_Z5, 8'hA5);
      pop_chk(PTZ_KIND_PAYLOAD, 8'h22);
      check(ov, 1'b0);
      push(PTZ_KIND_Z5, 8'h00);
      pop_chk(PTZ_KIND_Z5, 8'h3C);
   endtask
   task automatic t_port;
      logic [7:0] val [2] = '{8'hB6, 8'h4D};
      wr_reg(12'h982, 8'h08);
      rd_chk(12'h982, 8'h08);
      for (int k = 0; k < 2; k++)
      begin
         ins_byte = val[k];
         frame();
         repeat (700) tick();
         push(PTZ_KIND_Z5, 8'h00);
         pop_chk(PTZ_KIND_Z5, val[k]);
      end
   endtask
   task automatic t_force;
      wr_reg(12'h9BF, 8'h92);
      wr_reg(12'h9C3, 8'h34);
      wr_reg(12'h9B7, 8'h30);
      frame();
      rd_chk(12'h9C7, 8'h02);
      rd_chk(12'h9CB, 8'h34);
      push(PTZ_KIND_H1, 8'h00);
      pop_chk(PTZ_KIND_H1, 8'h92);
      push(PTZ_KIND_H2, 8'h00);
      pop_chk(PTZ_KIND_H2, 8'h34);
   endtask
   task automatic t_check;
      wr_reg(12'h9B7, 8'h34);
      rd_chk(12'h9B7, 8'h30);
      frame();
      rd_chk(12'h9CB, 8'h34);
      repeat (4) frame();
      rd_chk(12'h9CB, 8'h35);
      rd_chk(12'h9C7, 8'h02);
   endtask
   // Negative stuff, then single and continuous NDF, with the check off.
   task automatic t_events;
      wr_reg(12'h9B7, 8'h08);
      frame();
      rd_chk(12'h9CB, 8'h34);
      push(PTZ_KIND_H1, 8'h00);
      pop_chk(PTZ_KIND_H1, 8'h63);
      push(PTZ_KIND_H2, 8'h00);
      pop_chk(PTZ_KIND_H2, 8'h60);
      wr_reg(12'h9BF, 8'h02);
      wr_reg(12'h9C3, 8'h56);
      wr_reg(12'h9B7, 8'h01);
      frame();
      rd_chk(12'h9CB, 8'h56);
      push(PTZ_KIND_H1, 8'h00);
      pop_chk(PTZ_KIND_H1, 8'h92);
      frame();
      push(PTZ_KIND_H1, 8'h00);
      pop_chk(PTZ_KIND_H1, 8'h62);
      wr_reg(12'h9B7, 8'h02);
      frame();
      push(PTZ_KIND_H1, 8'h00);
      pop_chk(PTZ_KIND_H1, 8'h92);
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      t_regs();
      t_soft();
      t_port();
      t_force();
      t_check();
      t_events();
      wrap_up();
   end
   initial
   begin
      #40000;
      err_total++;
      wrap_up();
   end
endmodule // ptz_tx_path_tb_top
`default_nettype wire
